// [swc_sleep_wake_control.sv]
// sleep entry, wake-up sourcing and start-up delay control for an 8-bit core, APB register slave
// assumes core pulses for sleep/retire come from pclk logic; wake pins and master clear are asynchronous, other resets come from pclk logic
//
// Contract
// - sleep enters powerdown, clears watchdog and postscaler
// - sleep entry clears powerdown flag, sets timeout flag
// - oscillator off asleep; ports hold state
// - watchdog reset never drives master clear low
// - listed resets and interrupts end sleep
// - only listed peripheral interrupts may wake
// - reset wake resets device; interrupt wake continues
// - powerdown set at powerup; timeout cleared by watchdog
// - prefetch PC plus one during sleep
// - individual enable gates wake; global disable ignored
// - run next instruction, then vector if enabled
// - pending enabled interrupt aborts sleep immediately
// - every wake clears the watchdog
// - crystal/lowfreq interrupt wake holds reset 1024 periods
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
module swc_sleep_wake_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_exec,
   input wire logic insn_retire,
   input wire logic [15:0] pc,
   input wire logic por_event,
   input wire logic bor_event,
   input wire logic master_clear_pin_n,
   input wire logic wdt_timeout,
   input wire logic external_interrupt_pin,
   input wire logic portb_change,
   input wire logic timer0_clock_input,
   input wire logic [5:0] periph_wake_req,
   output logic [15:0] prefetch_addr,
   output logic prefetch_req,
   output logic osc_driver_en,
   output logic port_hold,
   output logic wdt_clear,
   output logic postscaler_clear,
   output logic device_reset,
   output logic master_clear_drive_n,
   output logic dummy_cycle,
   output logic vector_req,
   output logic asleep,
   output logic irq
);
   import swc_pkg::*;
   // ************************************
   // synchronised external inputs
   // ************************************
   logic [9:0] raw_async;
   logic [9:0] syn;
   assign raw_async = {periph_wake_req, timer0_clock_input, portb_change, external_interrupt_pin,
                       ~master_clear_pin_n};
   swc_sync #(.W(10)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d(raw_async),
      .q(syn)
   );
   logic mclr_s;
   logic ext_s;
   logic rbc_s;
   logic t0_s;
   logic [5:0] per_s;
   assign mclr_s = syn[0];
   assign ext_s = syn[1];
   assign rbc_s = syn[2];
   assign t0_s = syn[3];
   assign per_s = syn[9:4];
   logic ext_d;
   logic t0_d;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_d <= 1'b0;
         t0_d <= 1'b0;
      end else begin
         ext_d <= ext_s;
         t0_d <= t0_s;
      end
   end
   // ************************************
   // registers
   // ************************************
   swc_byte_t processor_status;
   swc_byte_t core_interrupt_status;
   logic [3:0] wake_config;
   logic [5:0] periph_enable;
   logic [5:0] periph_flag;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   swc_state_e state;
   swc_state_e next_state;
   logic [`SWC_OST_W-1:0] ost_cnt;
   logic wake_vector;
   logic wr;
   logic rd_phase;
   logic [9:0] word;
   assign wr = psel && penable && pwrite;
   assign rd_phase = psel && penable && !pwrite;
   assign word = paddr[11:2];
   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   logic mapped;
   always_comb begin
      mapped = (paddr[1:0] == 2'h0) && (word >= 10'(`SWC_IDX_PROCESSOR_STATUS))
               && (word <= 10'(`SWC_IDX_IRQ_MASK));
   end
   assign pslverr = psel && penable && !mapped;
   logic [7:0] wbyte;
   assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
   logic wr_ps;
   logic wr_cis;
   logic wr_cfg;
   logic wr_pe;
   logic wr_pf;
   logic wr_sc;
   logic wr_is;
   logic wr_im;
   assign wr_ps = wr && pstrb[0] && paddr == `SWC_ADDR_PROCESSOR_STATUS;
   assign wr_cis = wr && pstrb[0] && paddr == `SWC_ADDR_CORE_INT_STATUS;
   assign wr_cfg = wr && pstrb[0] && paddr == `SWC_ADDR_WAKE_CONFIG;
   assign wr_pe = wr && pstrb[0] && paddr == `SWC_ADDR_PERIPH_ENABLE;
   assign wr_pf = wr && pstrb[0] && paddr == `SWC_ADDR_PERIPH_FLAG;
   assign wr_sc = wr && pstrb[0] && paddr == `SWC_ADDR_SLEEP_CTRL;
   assign wr_is = wr && pstrb[0] && paddr == `SWC_ADDR_IRQ_STATUS;
   assign wr_im = wr && pstrb[0] && paddr == `SWC_ADDR_IRQ_MASK;
   // ************************************
   // wake sources
   // ************************************
   logic reset_src;
   logic [3:0] core_flag_set;
   logic [3:0] core_flags;
   logic [3:0] core_enables;
   logic int_pending;
   logic sleep_go;
   logic glint_dis;
   assign reset_src = por_event || bor_event || mclr_s || (wdt_timeout && wake_config[`SWC_WC_WDT_ENABLE]);
   // flags [7]=peripheral, [6]=timer0 input, [5]=port B, [4]=external pin
   assign core_flag_set = {|(per_s & periph_enable), t0_s && !t0_d, rbc_s, ext_s && !ext_d};
   assign core_flags = core_interrupt_status[7:4];
   assign core_enables = core_interrupt_status[3:0];
   assign int_pending = |(core_flags & core_enables);
   assign glint_dis = processor_status[`SWC_PS_GLOBAL_INT_DISABLE];
   assign sleep_go = (state == SWC_RUN) && (sleep_exec || wr_sc && wbyte[0]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_interrupt_status <= `SWC_CIS_RESET;
      end else if (reset_src) begin
         core_interrupt_status <= `SWC_CIS_RESET;
      end else begin
         // hardware set wins over a software clear in the same cycle
         core_interrupt_status[7:4] <= (wr_cis ? wbyte[7:4] : core_flags) | core_flag_set;
         if (wr_cis) begin
            core_interrupt_status[3:0] <= wbyte[3:0];
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_flag <= 6'h00;
      end else begin
         periph_flag <= ((wr_pf) ? (periph_flag & ~wbyte[5:0]) : periph_flag) | per_s;
      end
   end
   // ************************************
   // sleep / wake sequencer
   // ************************************
   // rc mode restarts at once; crystal and low-frequency modes need the start-up hold
   logic ost_needed;
   assign ost_needed = wake_config[2:1] == `SWC_OSC_CRYSTAL || wake_config[2:1] == `SWC_OSC_LOWFREQ;
   always_comb begin
      next_state = state;
      case (state)
         SWC_RUN: begin
            if (sleep_go && !int_pending) begin
               next_state = SWC_SLEEP;
            end
         end
         SWC_SLEEP: begin
            if (reset_src) begin
               next_state = SWC_RUN;
            end else if (int_pending) begin
               next_state = ost_needed ? SWC_OST : SWC_POST;
            end
         end
         SWC_OST: begin
            if (ost_cnt == `SWC_OST_W'(`SWC_OST_PERIODS - 1)) begin
               next_state = SWC_POST;
            end
         end
         SWC_POST: begin
            if (insn_retire) begin
               next_state = wake_vector ? SWC_DUMMY : SWC_RUN;
            end
         end
         SWC_DUMMY: begin
            next_state = SWC_RUN;
         end
         default: begin
            next_state = SWC_RUN;
         end
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SWC_RUN;
      end else if (reset_src && state != SWC_SLEEP) begin
         // in sleep the case decides, so a reset wake is also flagged there
         state <= SWC_RUN;
      end else begin
         state <= next_state;
      end
   end
   // oscillator is off during sleep, so periods are counted as pclk cycles once restarted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ost_cnt <= '0;
      end else if (state == SWC_OST) begin
         ost_cnt <= ost_cnt + `SWC_OST_W'(1);
      end else begin
         ost_cnt <= '0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_vector <= 1'b0;
      end else if (state == SWC_SLEEP && int_pending) begin
         // global disable steers vector or in-line only, it never gates the wake
         wake_vector <= !glint_dis;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prefetch_addr <= 16'h0000;
      end else if (sleep_go) begin
         prefetch_addr <= pc + 16'h0001;
      end
   end
   logic wake_now;
   assign wake_now = state == SWC_SLEEP && (reset_src || int_pending);
   assign prefetch_req = sleep_go;
   assign wdt_clear = sleep_go || wake_now || (state == SWC_RUN && sleep_go && int_pending);
   assign postscaler_clear = sleep_go && wake_config[`SWC_WC_POSTSCALER_EN];
   assign osc_driver_en = state != SWC_SLEEP;
   assign port_hold = state == SWC_SLEEP;
   assign asleep = state == SWC_SLEEP;
   assign device_reset = reset_src || state == SWC_OST;
   assign master_clear_drive_n = 1'b1;
   assign dummy_cycle = state == SWC_DUMMY;
   assign vector_req = state == SWC_DUMMY;
   // ************************************
   // processor status
   // ************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         processor_status <= `SWC_PS_RESET_POR;
      end else if (por_event || bor_event) begin
         processor_status <= `SWC_PS_RESET_POR;
         processor_status[`SWC_PS_POR] <= !por_event;
         processor_status[`SWC_PS_BOR] <= !bor_event;
      end else if (wdt_timeout && wake_config[`SWC_WC_WDT_ENABLE]) begin
         processor_status[`SWC_PS_TIMEOUT] <= 1'b0;
         processor_status[`SWC_PS_GLOBAL_INT_DISABLE] <= 1'b1;
      end else if (mclr_s) begin
         // resets outrank sleep entry, so a reset cycle never clears powerdown
         processor_status[`SWC_PS_GLOBAL_INT_DISABLE] <= 1'b1;
      end else if (sleep_go) begin
         processor_status[`SWC_PS_POWERDOWN] <= 1'b0;
         processor_status[`SWC_PS_TIMEOUT] <= 1'b1;
      end else if (wr_ps) begin
         processor_status[`SWC_PS_GLOBAL_INT_DISABLE] <= wbyte[`SWC_PS_GLOBAL_INT_DISABLE];
         processor_status[`SWC_PS_POR] <= processor_status[`SWC_PS_POR] | wbyte[`SWC_PS_POR];
         processor_status[`SWC_PS_BOR] <= processor_status[`SWC_PS_BOR] | wbyte[`SWC_PS_BOR];
      end
   end
   // ************************************
   // configuration and interrupt registers
   // ************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_config <= 4'h0;
         periph_enable <= 6'h00;
         irq_mask <= 3'h0;
      end else begin
         if (wr_cfg) begin
            wake_config <= wbyte[3:0];
         end
         if (wr_pe) begin
            periph_enable <= wbyte[5:0];
         end
         if (wr_im) begin
            irq_mask <= wbyte[2:0];
         end
      end
   end
   // slept is flagged only when sleep really takes effect, not on a blocked or reset cycle
   logic [2:0] irq_set;
   assign irq_set = {state == SWC_SLEEP && reset_src, state == SWC_SLEEP && !reset_src && int_pending,
                     state == SWC_RUN && next_state == SWC_SLEEP && !reset_src};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= 3'h0;
      end else begin
         irq_status <= (wr_is ? (irq_status & ~wbyte[2:0]) : irq_status) | irq_set;
      end
   end
   assign irq = |(irq_status & irq_mask);
   // ************************************
   // read data
   // ************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         // staged in the setup cycle so zero-wait reads still come from a flop
         case (paddr)
            `SWC_ADDR_PROCESSOR_STATUS: prdata <= {24'h000000, 2'h0, processor_status[5:0]};
            `SWC_ADDR_CORE_INT_STATUS: prdata <= {24'h000000, core_interrupt_status};
            `SWC_ADDR_WAKE_CONFIG: prdata <= {28'h0000000, wake_config};
            `SWC_ADDR_PERIPH_ENABLE: prdata <= {26'h0000000, periph_enable};
            `SWC_ADDR_PERIPH_FLAG: prdata <= {26'h0000000, periph_flag};
            `SWC_ADDR_SLEEP_CTRL: prdata <= {29'h00000000, state};
            `SWC_ADDR_IRQ_STATUS: prdata <= {29'h00000000, irq_status};
            `SWC_ADDR_IRQ_MASK: prdata <= {29'h00000000, irq_mask};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
   logic unused_rd;
   assign unused_rd = rd_phase;
endmodule : swc_sleep_wake_control

// [swc_regs.svh]
// sleep/wake controller constants: register offsets, field positions, reset values, timing counts
// assumes inclusion by bare name from the package and the design files
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH
// printed offsets 06h/07h are not multiples of four: index kept, byte address is four times it
`define SWC_IDX_PROCESSOR_STATUS 8'h06
`define SWC_IDX_CORE_INT_STATUS 8'h07
`define SWC_IDX_WAKE_CONFIG 8'h08
`define SWC_IDX_PERIPH_ENABLE 8'h09
`define SWC_IDX_PERIPH_FLAG 8'h0A
`define SWC_IDX_SLEEP_CTRL 8'h0B
`define SWC_IDX_IRQ_STATUS 8'h0C
`define SWC_IDX_IRQ_MASK 8'h0D
`define SWC_ADDR_PROCESSOR_STATUS 12'h018
`define SWC_ADDR_CORE_INT_STATUS 12'h01C
`define SWC_ADDR_WAKE_CONFIG 12'h020
`define SWC_ADDR_PERIPH_ENABLE 12'h024
`define SWC_ADDR_PERIPH_FLAG 12'h028
`define SWC_ADDR_SLEEP_CTRL 12'h02C
`define SWC_ADDR_IRQ_STATUS 12'h030
`define SWC_ADDR_IRQ_MASK 12'h034
// processor_status fields
`define SWC_PS_STACK_AVAIL 5
`define SWC_PS_GLOBAL_INT_DISABLE 4
`define SWC_PS_TIMEOUT 3
`define SWC_PS_POWERDOWN 2
`define SWC_PS_POR 1
`define SWC_PS_BOR 0
`define SWC_PS_RESET_POR 8'h3C
// core_interrupt_status: flags in [7:4], enables in [3:0]
`define SWC_CIS_RESET 8'h00
// wake_config fields
`define SWC_WC_WDT_ENABLE 0
`define SWC_WC_OSC_MODE_LSB 1
`define SWC_WC_POSTSCALER_EN 3
// oscillator modes
`define SWC_OSC_RC 2'h0
`define SWC_OSC_CRYSTAL 2'h1
`define SWC_OSC_LOWFREQ 2'h2
// start-up timer: oscillator periods held in reset
`define SWC_OST_PERIODS 1024
`define SWC_OST_W 11
// irq status bits
`define SWC_IRQ_SLEPT 0
`define SWC_IRQ_WOKE_INT 1
`define SWC_IRQ_WOKE_RESET 2
`endif

// [swc_pkg.sv]
// sleep/wake controller types
// assumes swc_regs.svh is on the include path
package swc_pkg;
   `include "swc_regs.svh"
   typedef enum logic [2:0] {
      SWC_RUN = 3'h0,
      SWC_SLEEP = 3'h1,
      SWC_OST = 3'h3,
      SWC_POST = 3'h2,
      SWC_DUMMY = 3'h6
   } swc_state_e;
   typedef logic [7:0] swc_byte_t;
endpackage : swc_pkg

// [swc_sync.sv]
// two-flop synchroniser for a bundle of asynchronous levels
// assumes a single destination clock; first stage read only by second
`timescale 1ns/100ps
module swc_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : swc_sync

// [swc_checker.sv]
// port-level checks for the sleep/wake controller
// assumes a single pclk domain and binding onto swc_sleep_wake_control
`timescale 1ns/100ps
module swc_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic sleep_exec,
   input wire logic [15:0] pc,
   input wire logic por_event,
   input wire logic wdt_timeout,
   input wire logic [15:0] prefetch_addr,
   input wire logic prefetch_req,
   input wire logic osc_driver_en,
   input wire logic port_hold,
   input wire logic wdt_clear,
   input wire logic device_reset,
   input wire logic master_clear_drive_n,
   input wire logic dummy_cycle,
   input wire logic asleep
);
   // ***************
   // assertions
   // ***************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_sleep_clr; sleep_exec |-> wdt_clear && prefetch_req; endproperty
   a_sleep_clr: assert property (p_sleep_clr) else $error("no clear or prefetch at sleep");
   property p_entry; $rose(asleep) |-> $past(sleep_exec); endproperty
   a_entry: assert property (p_entry) else $error("sleep entered without instruction");
   property p_hold; asleep |-> !osc_driver_en && port_hold; endproperty
   a_hold: assert property (p_hold) else $error("oscillator on or ports free while asleep");
   property p_mclr; wdt_timeout |-> master_clear_drive_n throughout 1'b1 [*3]; endproperty
   a_mclr: assert property (p_mclr) else $error("master clear driven low");
   property p_pf; $rose(asleep) |-> prefetch_addr == $past(pc) + 16'h0001; endproperty
   a_pf: assert property (p_pf) else $error("prefetch address wrong");
   property p_wake; $fell(asleep) |-> wdt_clear || $past(wdt_clear); endproperty
   a_wake: assert property (p_wake) else $error("watchdog not cleared on wake");
   property p_rst; (por_event || wdt_timeout) |-> device_reset; endproperty
   a_rst: assert property (p_rst) else $error("reset source without device reset");
   property p_dummy; dummy_cycle |=> !dummy_cycle; endproperty
   a_dummy: assert property (p_dummy) else $error("dummy cycle longer than one");
endmodule : swc_checker
bind swc_sleep_wake_control swc_checker chk_u (.pclk, .presetn, .sleep_exec, .pc, .por_event, .wdt_timeout,
   .prefetch_addr, .prefetch_req, .osc_driver_en, .port_hold, .wdt_clear, .device_reset, .master_clear_drive_n,
   .dummy_cycle, .asleep);

// [swc_core_model.sv]
// processor core stand-in: sleep instruction and instruction retire pulses
// assumes callers are synchronous to pclk
`timescale 1ns/100ps
module swc_core_model (
   input wire logic pclk,
   output logic sleep_exec,
   output logic insn_retire,
   output logic [15:0] pc
);
   // ***************
   // core actions
   // ***************
   initial begin
      sleep_exec = 1'b0;
      insn_retire = 1'b0;
      pc = 16'h0000;
   end
   task do_sleep(input logic [15:0] at);
      @(posedge pclk);
      sleep_exec <= 1'b1;
      pc <= at;
      @(posedge pclk);
      sleep_exec <= 1'b0;
      pc <= at + 16'h0001;
   endtask : do_sleep
   // instruction after sleep is a no-op; gap models a slow core
   task retire(input int gap);
      repeat (gap) @(posedge pclk);
      @(posedge pclk);
      insn_retire <= 1'b1;
      @(posedge pclk);
      insn_retire <= 1'b0;
   endtask : retire
endmodule : swc_core_model

// [tb_top.sv]
// self-checking bench for the sleep/wake controller over APB
// assumes swc_pkg, the design, checker and core model are compiled first
`timescale 1ns/100ps
module tb_top;
   import swc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic ext_pin = 1'b0, mclr_n = 1'b1, wdt_to = 1'b0, por_ev = 1'b0, bor_ev = 1'b0;
   logic ps_clr, pf_req, mclr_drv_n;
   logic [7:0] wake_src = 8'h00;
   logic [15:0] pf_addr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, rd;
   logic [3:0] pstrb = 4'h0;
   logic pready, pslverr, sleep_exec, insn_retire, osc_driver_en, port_hold, wdt_clear;
   logic device_reset, dummy_cycle, vector_req, asleep, irq;
   logic [15:0] pc;
   int err_count = 0, n_checks = 0, k, n, dummies, vectors, s, ps_seen = 0, pf_seen = 0, mclr_low = 0;
   swc_sleep_wake_control dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleep_exec(sleep_exec), .insn_retire(insn_retire), .pc(pc), .por_event(por_ev), .bor_event(bor_ev),
      .master_clear_pin_n(mclr_n), .wdt_timeout(wdt_to), .external_interrupt_pin(ext_pin),
      .portb_change(wake_src[0]), .timer0_clock_input(wake_src[1]), .periph_wake_req(wake_src[7:2]),
      .prefetch_addr(pf_addr), .prefetch_req(pf_req), .osc_driver_en(osc_driver_en), .port_hold(port_hold),
      .wdt_clear(wdt_clear), .postscaler_clear(ps_clr), .device_reset(device_reset),
      .master_clear_drive_n(mclr_drv_n), .dummy_cycle(dummy_cycle), .vector_req(vector_req),
      .asleep(asleep), .irq(irq));
   swc_core_model core_u (.pclk(pclk), .sleep_exec(sleep_exec), .insn_retire(insn_retire), .pc(pc));
   initial begin
      forever #20 pclk = ~pclk;
   end
   // pulse outputs counted at each edge, read later away from the launching edge
   always @(posedge pclk) begin
      ps_seen <= ps_seen + int'(ps_clr === 1'b1);
      pf_seen <= pf_seen + int'(pf_req === 1'b1);
      mclr_low <= mclr_low + int'(mclr_drv_n !== 1'b1);
   end
   // ***************
   // tasks
   // ***************
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         err_count++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wait_on(input logic v, input int lim);
      n = 0;
      while (((lim > 0) ? asleep : device_reset) !== v && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 3000) begin
         err_count++;
         end_sim();
      end
   endtask : wait_on
   task watch;
      dummies = 0;
      vectors = 0;
      repeat (8) begin
         @(posedge pclk);
         dummies += int'(dummy_cycle === 1'b1);
         vectors += int'(vector_req === 1'b1);
      end
   endtask : watch
   // ***************
   // sequence
   // ***************
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h018, 32'h00000000);
      chk("status reset", 32'h0000003C, rd);
      apb(1'b0, 12'hFFC, 32'h00000000);
      chk("unmapped error", 32'h00000001, {31'h0, err});
      chk("unmapped read", 32'h00000000, rd);
      apb(1'b1, 12'h01C, 32'h00000001);
      apb(1'b1, 12'h034, 32'h00000007);
      core_u.do_sleep(16'h1234);
      wait_on(1'b1, 1);
      apb(1'b0, 12'h018, 32'h00000000);
      chk("status asleep", 32'h00000038, rd);
      chk("prefetch address", 32'h00001235, {16'h0000, pf_addr});
      chk("prefetch pulse", 32'h00000001, pf_seen);
      apb(1'b0, 12'h030, 32'h00000000);
      chk("irq status", 32'h00000001, rd);
      chk("irq high", 32'h00000001, {31'h0, irq});
      apb(1'b1, 12'h030, 32'h00000001);
      @(posedge pclk);
      chk("irq low", 32'h00000000, {31'h0, irq});
      ext_pin <= 1'b1;
      wait_on(1'b0, 1);
      chk("no reset on int wake", 32'h00000000, {31'h0, device_reset});
      core_u.retire(2);
      watch();
      chk("inline vector", 32'h00000000, vectors);
      core_u.do_sleep(16'h2000);
      repeat (3) @(posedge pclk);
      chk("pending aborts sleep", 32'h00000000, {31'h0, asleep});
      apb(1'b0, 12'h018, 32'h00000000);
      chk("pending flags", 32'h00000008, rd & 32'h0000000C);
      ext_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b1, 12'h01C, 32'h00000001);
      apb(1'b1, 12'h018, 32'h0000002C);
      apb(1'b1, 12'h020, 32'h0000000B);
      core_u.do_sleep(16'h3000);
      wait_on(1'b1, 1);
      ext_pin <= 1'b1;
      wait_on(1'b1, 0);
      wait_on(1'b0, 0);
      chk("start-up hold", 32'd1024, n);
      chk("postscaler cleared", 32'h00000001, ps_seen);
      core_u.retire(0);
      watch();
      chk("dummy cycles", 32'h00000001, dummies);
      chk("vector taken", 32'h00000001, {31'h0, vectors > 0});
      ext_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b1, 12'h01C, 32'h00000000);
      core_u.do_sleep(16'h4000);
      wait_on(1'b1, 1);
      wdt_to <= 1'b1;
      @(posedge pclk);
      wdt_to <= 1'b0;
      wait_on(1'b0, 1);
      apb(1'b0, 12'h018, 32'h00000000);
      chk("timeout cleared", 32'h00000000, rd & 32'h00000008);
      apb(1'b0, 12'h030, 32'h00000000);
      chk("reset wake irq", 32'h00000004, rd & 32'h00000004);
      apb(1'b1, 12'h030, 32'h00000007);
      core_u.do_sleep(16'h5000);
      wait_on(1'b1, 1);
      mclr_n <= 1'b0;
      repeat (4) @(posedge pclk);
      mclr_n <= 1'b1;
      wait_on(1'b0, 1);
      chk("master clear wake", 32'h00000000, {31'h0, asleep});
      apb(1'b0, 12'h030, 32'h00000000);
      chk("master clear irq", 32'h00000004, rd & 32'h00000004);
      apb(1'b1, 12'h020, 32'h00000000);
      apb(1'b1, 12'h01C, 32'h0000000E);
      // port B level, timer0 edge, then a capture request whose peripheral enable is still off
      for (s = 0; s < 3; s++) begin
         core_u.do_sleep(16'h6000);
         wait_on(1'b1, 1);
         wake_src <= 8'h01 << s;
         repeat (6) @(posedge pclk);
         chk("disabled source ignored", {31'h0, s == 2}, {31'h0, asleep});
         if (s == 2) begin
            apb(1'b1, 12'h024, 32'h00000001);
         end
         wait_on(1'b0, 1);
         wake_src <= 8'h00;
         core_u.retire(0);
         apb(1'b1, 12'h01C, 32'h0000000E);
      end
      core_u.do_sleep(16'h7000);
      wait_on(1'b1, 1);
      por_ev <= 1'b1;
      @(posedge pclk);
      por_ev <= 1'b0;
      wait_on(1'b0, 1);
      apb(1'b0, 12'h018, 32'h00000000);
      chk("power-on flags", 32'h0000003D, rd);
      bor_ev <= 1'b1;
      @(posedge pclk);
      bor_ev <= 1'b0;
      apb(1'b0, 12'h018, 32'h00000000);
      chk("brown-out flags", 32'h0000003E, rd);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h018, 32'h00000000);
      chk("status after reset", 32'h0000003C, rd);
      apb(1'b0, 12'h030, 32'h00000000);
      chk("irq status after reset", 32'h00000000, rd);
      chk("master clear never driven", 32'h00000000, mclr_low);
      end_sim();
   end
endmodule : tb_top
